// [pkg/bsc_pkg.sv]
// constants, types and states shared by the boundary-scan port
// Function
// - tap state machine and instruction handling follow the boundary-scan standard
// - boundary tests are refused while a configuration load runs
// - instruction register is ten bits; controller shifts exactly ten per load
// - user signature is 32 bits: 7 from the design, 25 fixed
// - sample/preload snapshots pins without disturbing them and preloads a pattern
// - external test drives the pattern on outputs and captures the inputs
// - bypass puts a single-bit stage between serial input and output
// - user-signature instruction shifts the user signature out serially
// - identification instruction shifts the 32-bit identification value out
// - identification order is version, part number, maker code, constant bit
// - identification lsb reads one and leaves first
// - boundary register has 438 cells on the smallest variant, 1050 largest
// - reconfiguration instructions load configuration through the test port
package bsc_pkg;

   // -------------------------------------------------------------------
   // lengths
   // -------------------------------------------------------------------
   localparam int IR_LEN      = 10;
   localparam int DR_LEN      = 32;
   localparam int ID_VER_LEN  = 4;
   localparam int ID_PART_LEN = 16;
   localparam int ID_MFR_LEN  = 11;
   localparam int USER_LEN    = 7;
   localparam int USER_FIX_LEN = 25;
   localparam int BSR_LEN     = 438;
   localparam int BSR_LEN_MAX = 1050;

   // -------------------------------------------------------------------
   // instruction codes and fixed values
   // -------------------------------------------------------------------
   localparam logic [IR_LEN-1:0] INS_EXTEST    = 10'h000;
   localparam logic [IR_LEN-1:0] INS_CFG_START = 10'h002;
   localparam logic [IR_LEN-1:0] INS_CFG_DATA  = 10'h003;
   localparam logic [IR_LEN-1:0] INS_CFG_DONE  = 10'h004;
   localparam logic [IR_LEN-1:0] INS_SAMPLE    = 10'h005;
   localparam logic [IR_LEN-1:0] INS_IDCODE    = 10'h006;
   localparam logic [IR_LEN-1:0] INS_USERCODE  = 10'h007;
   localparam logic [IR_LEN-1:0] INS_BYPASS    = 10'h3FF;
   localparam logic [IR_LEN-1:0] IR_CAPTURE    = 10'h001;
   localparam logic [IR_LEN-1:0] IR_RESET_VAL  = INS_IDCODE;
   localparam logic [DR_LEN-1:0] DR_RESET_VAL  = 32'h0000_0000;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bsc_pins_s;

   typedef enum logic [3:0] {
      ST_TLR    = 4'hF,
      ST_RTI    = 4'hC,
      ST_SEL_DR = 4'h7,
      ST_CAP_DR = 4'h6,
      ST_SH_DR  = 4'h2,
      ST_EX1_DR = 4'h1,
      ST_PAU_DR = 4'h3,
      ST_EX2_DR = 4'h0,
      ST_UPD_DR = 4'h5,
      ST_SEL_IR = 4'h4,
      ST_CAP_IR = 4'hE,
      ST_SH_IR  = 4'hA,
      ST_EX1_IR = 4'h9,
      ST_PAU_IR = 4'hB,
      ST_EX2_IR = 4'h8,
      ST_UPD_IR = 4'hD
   } bsc_tap_e;

   typedef enum logic [2:0] {
      DR_BYPASS = 3'h0,
      DR_ID     = 3'h1,
      DR_USER   = 3'h2,
      DR_BSR    = 3'h3,
      DR_CFG    = 3'h4
   } bsc_dr_e;

endpackage

// [sim/bsc_ctrl_model.sv]
// test controller model driving the scan link
`timescale 1ns/1ps
module bsc_ctrl_model
   import bsc_pkg::*;
(
   // clock
   input  wire logic sys_clk,
   // scan link
   output bsc_pins_s scan_in,
   input  wire logic tdo
);
   localparam int HALF = 10;

   initial scan_in = '0;

   // one test clock period; clock stands low between calls
   task automatic step(input logic tms, input logic tdi, output logic so);
      @(posedge sys_clk);
      scan_in.tms <= tms;
      scan_in.tdi <= tdi;
      repeat (HALF) @(posedge sys_clk);
      scan_in.tck <= 1'b1;
      so = tdo;
      repeat (HALF) @(posedge sys_clk);
      scan_in.tck <= 1'b0;
   endtask

   // idle -> capture -> shift n bits lsb first -> update -> idle
   task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din,
                       output logic [BSR_LEN-1:0] dout);
      logic b;
      dout = '0;
      step(1'b1, 1'b0, b);
      if (ir)
         step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
   endtask
endmodule

// [sim/bsc_scan_port_props.sv]
// checker of the scan port's sequencing seen at its ports
`timescale 1ns/1ps
module bsc_scan_port_props
   import bsc_pkg::*;
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // scan link
   input  bsc_pins_s               scan_in,
   input  wire logic               tdo,
   input  wire logic               tdo_oe,
   // configuration, pins and state
   input  wire logic               cfg_active,
   input  wire logic               cfg_strobe,
   input  wire logic [BSR_LEN-1:0] core_out,
   input  wire logic [BSR_LEN-1:0] pin_out,
   input  bsc_tap_e                tap_state
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_oe_on;
      $rose(tdo_oe);
   endsequence
   sequence s_cfg_on;
      $rose(cfg_active);
   endsequence

   chk_reset_leave: assert property (!$past(rst_n) |-> tap_state == ST_TLR && !tdo_oe && !cfg_active)
      else $error("port not idle after reset");
   chk_oe_start: assert property (s_oe_on |-> tap_state inside {ST_SH_DR, ST_SH_IR})
      else $error("output enabled outside shift");
   chk_oe_window: assert property (tdo_oe |-> tap_state inside {ST_SH_DR, ST_EX1_DR, ST_SH_IR, ST_EX1_IR})
      else $error("output enable held too long");
   chk_tdo_at_fall: assert property ($changed(tdo) |-> !$past(scan_in.tck, 2))
      else $error("serial out moved while test clock high");
   chk_state_at_rise: assert property ($changed(tap_state) |-> $past(scan_in.tck, 2))
      else $error("state moved while test clock low");
   chk_strobe_pulse: assert property (cfg_strobe |=> !cfg_strobe)
      else $error("config strobe longer than one cycle");
   chk_strobe_cfg: assert property (cfg_strobe |-> cfg_active && tap_state inside {ST_SH_DR, ST_EX1_DR})
      else $error("config strobe outside data shift");
   chk_cfg_start: assert property (s_cfg_on |-> tap_state inside {ST_UPD_IR, ST_RTI, ST_SEL_DR})
      else $error("config load began outside instruction update");
   chk_pins_core: assert property (cfg_active && $past(cfg_active) |-> pin_out == $past(core_out))
      else $error("pins not following core while configuring");
endmodule

// [sim/bsc_scan_port_tb.sv]
// self-checking bench of the boundary-scan port
`timescale 1ns/1ps
module bsc_scan_port_tb;
   import bsc_pkg::*;
   typedef logic [BSR_LEN-1:0] bsc_vec_t;
   typedef struct packed {
      logic [IR_LEN-1:0] code;
      logic [DR_LEN-1:0] din;
      logic [DR_LEN-1:0] dexp;
   } bsc_row_s;
   // identification and user-signature fields and test patterns, values arbitrary
   localparam logic [3:0]  T_VER   = 4'h9;
   localparam logic [15:0] T_PART  = 16'h5E21;
   localparam logic [10:0] T_MAKER = 11'h0D3;
   localparam logic [24:0] T_FIX   = 25'h1A2B3C4;
   localparam logic [31:0] T_ID    = {T_VER, T_PART, T_MAKER, 1'b1};
   localparam logic [31:0] PAT     = 32'hC3A5_0F96;
   localparam bsc_vec_t    PA      = {73{6'h2D}};
   localparam bsc_vec_t    PB      = {73{6'h12}};
   localparam bsc_vec_t    PC      = {146{3'h5}};
   localparam bsc_vec_t    PD      = {219{2'h1}};

   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   bsc_pins_s   scan_in;
   logic        tdo;
   logic        tdo_oe;
   logic        cfg_active;
   logic        cfg_bit;
   logic        cfg_strobe;
   bsc_vec_t    pin_in;
   bsc_vec_t    core_out;
   bsc_vec_t    pin_out;
   logic [6:0]  user_sig;
   bsc_tap_e    tap_state;
   bsc_vec_t    got;
   bsc_row_s    rows [4];
   logic [7:0]  cfg_seen = '0;
   int          n_strobe = 0;
   int          n_errors = 0;
   int          check_count = 0;
   logic        b;

   always #4 sys_clk = ~sys_clk;

   always @(posedge sys_clk)
      if (cfg_strobe === 1'b1)
      begin
         cfg_seen <= {cfg_bit, cfg_seen[7:1]};
         n_strobe <= n_strobe + 1;
      end

   bsc_scan_port #(.ID_VERSION(T_VER), .ID_PART(T_PART), .ID_MAKER(T_MAKER),
                   .USER_FIXED(T_FIX)) bsc_scan_port_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .scan_in(scan_in), .tdo(tdo), .tdo_oe(tdo_oe),
      .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .user_sig(user_sig),
      .cfg_active(cfg_active), .cfg_bit(cfg_bit), .cfg_strobe(cfg_strobe),
      .tap_state(tap_state));

   bsc_ctrl_model bsc_ctrl_model_i (.sys_clk(sys_clk), .scan_in(scan_in), .tdo(tdo));

   task automatic check(input bsc_vec_t seen, input bsc_vec_t exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic ir(input logic [IR_LEN-1:0] code);
      bsc_ctrl_model_i.scan(1'b1, IR_LEN, bsc_vec_t'(code), got);
      check(got, bsc_vec_t'(IR_CAPTURE));
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      pin_in = PA;
      core_out = PB;
      user_sig = 7'h5A;
      rows[0] = '{INS_IDCODE, 32'hFFFF_FFFF, T_ID};
      rows[1] = '{INS_USERCODE, 32'h0, {T_FIX, 7'h5A}};
      rows[2] = '{INS_BYPASS, PAT, {PAT[30:0], 1'b0}};
      rows[3] = '{10'h155, PAT, {PAT[30:0], 1'b0}};
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check(bsc_vec_t'(tap_state), bsc_vec_t'(ST_TLR));
      check(bsc_vec_t'(tdo_oe), bsc_vec_t'(1'b0));
      bsc_ctrl_model_i.step(1'b0, 1'b0, b);
      foreach (rows[i])
      begin
         ir(rows[i].code);
         bsc_ctrl_model_i.scan(1'b0, DR_LEN, bsc_vec_t'(rows[i].din), got);
         check(got, bsc_vec_t'(rows[i].dexp));
      end
      // snapshot and preload, then drive the preload
      ir(INS_SAMPLE);
      bsc_ctrl_model_i.scan(1'b0, BSR_LEN, PC, got);
      check(got, PA);
      check(pin_out, PB);
      ir(INS_EXTEST);
      check(pin_out, PC);
      bsc_ctrl_model_i.scan(1'b0, BSR_LEN, PD, got);
      check(got, PA);
      check(pin_out, PD);
      repeat (5) bsc_ctrl_model_i.step(1'b1, 1'b0, b);
      check(bsc_vec_t'(tap_state), bsc_vec_t'(ST_TLR));
      check(pin_out, PB);
      bsc_ctrl_model_i.step(1'b0, 1'b0, b);
      // configuration load, with a refused boundary test inside it
      ir(INS_CFG_START);
      check(bsc_vec_t'(cfg_active), bsc_vec_t'(1'b1));
      ir(INS_EXTEST);
      bsc_ctrl_model_i.scan(1'b0, DR_LEN, bsc_vec_t'(PAT), got);
      check(got, bsc_vec_t'({PAT[30:0], 1'b0}));
      check(pin_out, PB);
      ir(INS_CFG_DATA);
      bsc_ctrl_model_i.scan(1'b0, 8, bsc_vec_t'(8'hA6), got);
      check(bsc_vec_t'(cfg_seen), bsc_vec_t'(8'hA6));
      check(bsc_vec_t'(n_strobe), bsc_vec_t'(8));
      ir(INS_CFG_DONE);
      check(bsc_vec_t'(cfg_active), bsc_vec_t'(1'b0));
      // reset in mid-run restores the identification instruction
      ir(INS_USERCODE);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      check(bsc_vec_t'(tap_state), bsc_vec_t'(ST_TLR));
      check(bsc_vec_t'({tdo_oe, cfg_active}), bsc_vec_t'(2'b00));
      bsc_ctrl_model_i.step(1'b0, 1'b0, b);
      bsc_ctrl_model_i.scan(1'b0, DR_LEN, '0, got);
      check(got, bsc_vec_t'(T_ID));
      tally_and_finish();
   end
endmodule

bind bsc_scan_port bsc_scan_port_props bsc_scan_port_props_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .scan_in(scan_in), .tdo(tdo), .tdo_oe(tdo_oe),
   .cfg_active(cfg_active), .cfg_strobe(cfg_strobe), .core_out(core_out),
   .pin_out(pin_out), .tap_state(tap_state));

// [verilog/bsc_boundary_reg.sv]
// boundary register: pin capture, shift path, update latch and pin drive
`timescale 1ns/1ps
module bsc_boundary_reg
   import bsc_pkg::*;
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // capture, shift and update strobes, one cycle at a test clock rise; extest is a level, tdi the serial in
   input  wire logic               capture,
   input  wire logic               shift,
   input  wire logic               update,
   input  wire logic               extest,
   input  wire logic               tdi,
   // pins and core
   input  wire logic [BSR_LEN-1:0] pin_in,
   input  wire logic [BSR_LEN-1:0] core_out,
   output logic      [BSR_LEN-1:0] pin_out,
   // serial out
   output logic                    so
);

   typedef struct packed {
      logic [BSR_LEN-1:0] meta;
      logic [BSR_LEN-1:0] pins;
      logic [BSR_LEN-1:0] sh;
      logic [BSR_LEN-1:0] upd;
      logic [BSR_LEN-1:0] drv;
   } bsc_bsr_s;

   bsc_bsr_s r_q;
   bsc_bsr_s r_d;

   assign pin_out = r_q.drv;
   assign so      = r_q.sh[0];

   // -------------------------------------------------------------------
   // cells
   // -------------------------------------------------------------------
   always_comb
   begin
      r_d      = r_q;
      r_d.meta = pin_in;
      r_d.pins = r_q.meta;
      if (capture)
         r_d.sh = r_q.pins;
      else if (shift)
         r_d.sh = {tdi, r_q.sh[BSR_LEN-1:1]};
      if (update)
         r_d.upd = r_q.sh;
      r_d.drv = extest ? r_q.upd : core_out;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

endmodule

// [verilog/bsc_scan_port.sv]
// boundary-scan port top: link sampling, instructions, data registers
`timescale 1ns/1ps
module bsc_scan_port
   import bsc_pkg::*;
#(
   // identification fields, values arbitrary
   parameter logic [ID_VER_LEN-1:0]   ID_VERSION  = 4'h3,
   parameter logic [ID_PART_LEN-1:0]  ID_PART     = 16'hA5C3,
   parameter logic [ID_MFR_LEN-1:0]   ID_MAKER    = 11'h2B5,
   // fixed user-signature bits, value arbitrary
   parameter logic [USER_FIX_LEN-1:0] USER_FIXED  = 25'h0123456
)
(
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // scan link
   input  bsc_pins_s               scan_in,
   output logic                    tdo,
   output logic                    tdo_oe,
   // device pins and core
   input  wire logic [BSR_LEN-1:0] pin_in,
   input  wire logic [BSR_LEN-1:0] core_out,
   output logic      [BSR_LEN-1:0] pin_out,
   input  wire logic [USER_LEN-1:0] user_sig,
   // configuration stream
   output logic                    cfg_active,
   output logic                    cfg_bit,
   output logic                    cfg_strobe,
   // state
   output bsc_tap_e                tap_state
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      bsc_pins_s         meta;
      bsc_pins_s         smp;
      logic              tck_prev;
      logic [IR_LEN-1:0] ir_sh;
      logic [IR_LEN-1:0] ir;
      logic [DR_LEN-1:0] dr;
      logic              tdo;
      logic              tdo_oe;
      logic              cfg_active;
      logic              cfg_bit;
      logic              cfg_strobe;
   } bsc_top_s;

   localparam bsc_top_s TOP_RESET = '{
      meta:       '0,
      smp:        '0,
      tck_prev:   1'b0,
      ir_sh:      '0,
      ir:         IR_RESET_VAL,
      dr:         DR_RESET_VAL,
      tdo:        1'b0,
      tdo_oe:     1'b0,
      cfg_active: 1'b0,
      cfg_bit:    1'b0,
      cfg_strobe: 1'b0
   };

   bsc_top_s r_q;
   bsc_top_s r_d;

   logic     tck_rise;
   logic     tck_fall;
   bsc_dr_e  dr_sel;
   logic     bsr_cap;
   logic     bsr_shift;
   logic     bsr_upd;
   logic     bsr_extest;
   logic     bsr_so;

   // -------------------------------------------------------------------
   // edges of the sampled test clock
   // -------------------------------------------------------------------
   assign tck_rise = r_q.smp.tck & ~r_q.tck_prev;
   assign tck_fall = ~r_q.smp.tck & r_q.tck_prev;

   // -------------------------------------------------------------------
   // data register selection
   // -------------------------------------------------------------------
   always_comb
   begin
      unique case (r_q.ir)
         INS_EXTEST,
         INS_SAMPLE:
            dr_sel = r_q.cfg_active ? DR_BYPASS : DR_BSR;
         INS_IDCODE:    dr_sel = DR_ID;
         INS_USERCODE:  dr_sel = DR_USER;
         INS_CFG_DATA:  dr_sel = DR_CFG;
         default:       dr_sel = DR_BYPASS;
      endcase
   end

   assign bsr_cap    = tck_rise && (tap_state == ST_CAP_DR) && (dr_sel == DR_BSR);
   assign bsr_shift  = tck_rise && (tap_state == ST_SH_DR) && (dr_sel == DR_BSR);
   assign bsr_upd    = tck_rise && (tap_state == ST_UPD_DR) && (dr_sel == DR_BSR);
   assign bsr_extest = (r_q.ir == INS_EXTEST) && !r_q.cfg_active;

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb
   begin
      r_d            = r_q;
      r_d.meta       = scan_in;
      r_d.smp        = r_q.meta;
      r_d.tck_prev   = r_q.smp.tck;
      r_d.cfg_strobe = 1'b0;

      if (tck_rise)
      begin
         unique case (tap_state)
            ST_TLR:
               r_d.ir = IR_RESET_VAL;
            ST_CAP_IR:
               r_d.ir_sh = IR_CAPTURE;
            ST_SH_IR:
               r_d.ir_sh = {r_q.smp.tdi, r_q.ir_sh[IR_LEN-1:1]};
            ST_UPD_IR:
            begin
               r_d.ir = r_q.ir_sh;
               if (r_q.ir_sh == INS_CFG_START)
                  r_d.cfg_active = 1'b1;
               else if (r_q.ir_sh == INS_CFG_DONE)
                  r_d.cfg_active = 1'b0;
            end
            ST_CAP_DR:
            begin
               unique case (dr_sel)
                  DR_ID:
                     r_d.dr = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
                  DR_USER:
                     r_d.dr = {USER_FIXED, user_sig};
                  DR_BSR:
                     r_d.dr = r_q.dr;
                  DR_BYPASS,
                  DR_CFG:
                     r_d.dr[0] = 1'b0;
               endcase
            end
            ST_SH_DR:
            begin
               unique case (dr_sel)
                  DR_ID,
                  DR_USER:
                     r_d.dr = {r_q.smp.tdi, r_q.dr[DR_LEN-1:1]};
                  DR_BSR:
                     r_d.dr = r_q.dr;
                  DR_BYPASS:
                     r_d.dr[0] = r_q.smp.tdi;
                  DR_CFG:
                  begin
                     r_d.dr[0]      = r_q.smp.tdi;
                     r_d.cfg_bit    = r_q.smp.tdi;
                     r_d.cfg_strobe = r_q.cfg_active;
                  end
               endcase
            end
            default:
               r_d.dr = r_q.dr;
         endcase
      end

      // output changes on the falling edge, controller samples on the rise
      if (tck_fall)
      begin
         if (tap_state == ST_SH_IR)
         begin
            r_d.tdo    = r_q.ir_sh[0];
            r_d.tdo_oe = 1'b1;
         end
         else if (tap_state == ST_SH_DR)
         begin
            r_d.tdo    = (dr_sel == DR_BSR) ? bsr_so : r_q.dr[0];
            r_d.tdo_oe = 1'b1;
         end
         else
         begin
            r_d.tdo_oe = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         r_q <= TOP_RESET;
      else
         r_q <= r_d;
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign tdo        = r_q.tdo;
   assign tdo_oe     = r_q.tdo_oe;
   assign cfg_active = r_q.cfg_active;
   assign cfg_bit    = r_q.cfg_bit;
   assign cfg_strobe = r_q.cfg_strobe;

   // -------------------------------------------------------------------
   // submodules
   // -------------------------------------------------------------------
   bsc_tap_ctrl u_tap (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .tck_rise (tck_rise),
      .tms      (r_q.smp.tms),
      .state    (tap_state)
   );

   bsc_boundary_reg u_bsr (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .capture  (bsr_cap),
      .shift    (bsr_shift),
      .update   (bsr_upd),
      .extest   (bsr_extest),
      .tdi      (r_q.smp.tdi),
      .pin_in   (pin_in),
      .core_out (core_out),
      .pin_out  (pin_out),
      .so       (bsr_so)
   );

endmodule

// [verilog/bsc_tap_ctrl.sv]
// test access port state machine stepped on each test clock rise
`timescale 1ns/1ps
module bsc_tap_ctrl
   import bsc_pkg::*;
(
   // clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst_n,
   // sampled link
   input  wire logic     tck_rise,
   input  wire logic     tms,
   // state
   output bsc_tap_e      state
);

   typedef struct packed {
      bsc_tap_e st;
   } bsc_tap_s;

   bsc_tap_s r_q;
   bsc_tap_s r_d;

   assign state = r_q.st;

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb
   begin
      r_d = r_q;
      if (tck_rise)
      begin
         unique case (r_q.st)
            ST_TLR:    r_d.st = tms ? ST_TLR    : ST_RTI;
            ST_RTI:    r_d.st = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: r_d.st = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: r_d.st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  r_d.st = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: r_d.st = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: r_d.st = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: r_d.st = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: r_d.st = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: r_d.st = tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: r_d.st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  r_d.st = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: r_d.st = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: r_d.st = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: r_d.st = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: r_d.st = tms ? ST_SEL_DR : ST_RTI;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         r_q <= '{st: ST_TLR};
      else
         r_q <= r_d;
   end

endmodule
